// File: rtl/sfp_pkg.sv
// shared constants and types for the flash power-mode and rescue link
package sfp_pkg;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned DESELECT_TIME_MIN_NS = 50;
    localparam int unsigned DESELECT_CYC = (DESELECT_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] DESELECT_CYC_W = DESELECT_CYC[2:0];
    localparam logic [1:0] SCK_HALF_MAX = 2'h1;
    localparam logic [5:0] STEP1_LEN0 = 6'h07;
    localparam logic [5:0] STEP1_LEN1 = 6'h09;
    localparam logic [5:0] STEP1_LEN2 = 6'h0d;
    localparam logic [5:0] STEP1_LEN3 = 6'h11;
    localparam logic [5:0] STEP1_LEN4 = 6'h19;
    localparam logic [5:0] STEP1_LEN5 = 6'h21;
    localparam logic [2:0] STEP1_LAST = 3'h5;
    localparam logic [2:0] SEQ_FRAMES = 3'h7;
    localparam logic [5:0] PLR_LEN = 6'h08;
    localparam logic [5:0] RESCUE_LEN = 6'h10;
    localparam logic [5:0] CMD_LEN = 6'h08;
    localparam logic [5:0] CNT_MAX = 6'h3f;
    localparam logic [5:0] XIP_DUMMY_POS = 6'h18;
    localparam logic [7:0] CMD_ENTER_DPD = 8'h5a;
    localparam logic [7:0] CMD_RELEASE_DPD = 8'ha5;
    localparam logic [7:0] ARRAY_ERASED = 8'hff;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] NONVOLATILE_CONFIG_REG_RESET = 16'hffff;
    localparam int unsigned NONVOLATILE_CONFIG_REG_PROTO_LSB = 6;
    localparam int unsigned NONVOLATILE_CONFIG_REG_XIP_BIT = 3;
    localparam int unsigned STATUS_WIP_BIT = 0;

    typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} sfp_proto_type;
    typedef enum logic [1:0] {PM_STANDBY, PM_ACTIVE, PM_DPD} sfp_pmode_type;
    typedef enum logic [1:0] {OP_CMD, OP_PLR, OP_RESCUE} sfp_op_type;

    function automatic logic [5:0] step1_len(input logic [2:0] idx);
        case (idx)
            3'h0: step1_len = STEP1_LEN0;
            3'h1: step1_len = STEP1_LEN1;
            3'h2: step1_len = STEP1_LEN2;
            3'h3: step1_len = STEP1_LEN3;
            3'h4: step1_len = STEP1_LEN4;
            default: step1_len = STEP1_LEN5;
        endcase
    endfunction
endpackage

// File: rtl/sfp_if.sv
// link between host controller and flash device
`timescale 1ns/1ps
interface sfp_if;
    logic sck;
    logic cs_n;
    logic io0_o;
    logic io0_oe;
    logic io3_o;
    logic io3_oe;
    logic io0;
    logic io3;
    // pull-ups when nobody drives
    assign io0 = io0_oe ? io0_o : 1'b1;
    assign io3 = io3_oe ? io3_o : 1'b1;
    modport host (output sck, output cs_n, output io0_o, output io0_oe, output io3_o, output io3_oe);
    modport dev (input sck, input cs_n, input io0, input io3);
endinterface

// File: rtl/sfp_dev.sv
// flash device end: power modes, recovery sequences, delivery state
// Summary of operation
// - selected means active power mode, except in deep power-down
// - deselected: active until busy ends, then standby
// - enter command puts device in deep power-down
// - release command leaves deep power-down
// - power-loss recovery forces extended, no EXECUTE_IN_PLACE
// - rescue restores interface from config register, or extended after a power-loss recovery until reset
// - rescue touches interface only, not operations
// - host keeps steps ordered, deselect 50ns
// - step one: lines high, 7..33 clocks
// - power-loss step two: eight high clocks
// - rescue step two: sixteen high clocks
// - double rate: ones on both edges
// - after sequence, extended commands accepted; after rescue only if it restores extended, no EXECUTE_IN_PLACE
// - host should rewrite config register afterwards
// - delivered array bytes read FFh
// - delivered status register is 00h
// - delivered config register is FFFFh
// - first dummy bit one ends EXECUTE_IN_PLACE
// - step-one frames end EXECUTE_IN_PLACE, no reset
`timescale 1ns/1ps
module sfp_dev (
    sfp_if.dev lnk,
    input wire logic nrst,
    input wire logic busy,
    input wire logic nonvolatile_config_reg_wr,
    input wire logic [15:0] nonvolatile_config_reg_wdata,
    input wire logic pwr_loss,
    output sfp_pkg::sfp_pmode_type pmode,
    output sfp_pkg::sfp_proto_type proto,
    output logic execute_in_place,
    output logic [7:0] status,
    output logic [7:0] array_rd,
    output logic cmd_valid,
    output logic [7:0] cmd_code
);
    typedef enum {REC_SEEK, REC_ARMED} sfp_rec_type;

    function automatic sfp_pkg::sfp_proto_type nonvolatile_config_reg_proto(input logic [15:0] v);
        case (v[sfp_pkg::NONVOLATILE_CONFIG_REG_PROTO_LSB +: 2])
            2'h1: nonvolatile_config_reg_proto = sfp_pkg::PROTO_QUAD;
            2'h2: nonvolatile_config_reg_proto = sfp_pkg::PROTO_DUAL;
            default: nonvolatile_config_reg_proto = sfp_pkg::PROTO_EXT;
        endcase
    endfunction

    logic cs_prev_ff, nxt_cs_prev;
    logic [5:0] cnt_ff, nxt_cnt;
    logic ones_ff, nxt_ones;
    logic [7:0] shift_ff, nxt_shift;
    logic [2:0] idx_ff, nxt_idx;
    sfp_rec_type rec_ff, nxt_rec;
    sfp_pkg::sfp_pmode_type pmode_ff, nxt_pmode;
    sfp_pkg::sfp_proto_type proto_ff, nxt_proto;
    logic xip_ff, nxt_xip;
    logic lock_ff, nxt_lock;
    logic init_ff, nxt_init;
    logic [15:0] nonvolatile_config_reg_ff, nxt_nonvolatile_config_reg;
    logic [7:0] status_ff, nxt_status;
    logic [7:0] array_ff, nxt_array;
    logic cmdv_ff, nxt_cmdv;
    logic [7:0] cmd_ff, nxt_cmd;
    logic [5:0] cnt_base;
    logic ones_base;
    logic frame_end;

    always_comb begin
        nxt_cs_prev = lnk.cs_n;
        nxt_cnt = cnt_ff;
        nxt_ones = ones_ff;
        nxt_shift = shift_ff;
        nxt_idx = idx_ff;
        nxt_rec = rec_ff;
        nxt_pmode = pmode_ff;
        nxt_proto = proto_ff;
        nxt_xip = xip_ff;
        nxt_lock = lock_ff;
        nxt_init = 1'b1;
        nxt_nonvolatile_config_reg = nonvolatile_config_reg_ff;
        nxt_status = status_ff;
        nxt_status[sfp_pkg::STATUS_WIP_BIT] = busy;
        nxt_array = sfp_pkg::ARRAY_ERASED;
        nxt_cmdv = 1'b0;
        nxt_cmd = cmd_ff;
        frame_end = lnk.cs_n && !cs_prev_ff;
        cnt_base = cs_prev_ff ? 6'h00 : cnt_ff;
        ones_base = cs_prev_ff ? 1'b1 : ones_ff;
        // power-on state comes from the config register, or is scrambled by a torn write
        if (!init_ff) begin
            if (pwr_loss) begin
                nxt_proto = sfp_pkg::PROTO_QUAD;
                nxt_xip = 1'b1;
            end else begin
                nxt_proto = nonvolatile_config_reg_proto(nonvolatile_config_reg_ff);
                nxt_xip = !nonvolatile_config_reg_ff[sfp_pkg::NONVOLATILE_CONFIG_REG_XIP_BIT];
            end
        end
        if (nonvolatile_config_reg_wr) begin
            nxt_nonvolatile_config_reg = nonvolatile_config_reg_wdata;
        end
        if (!lnk.cs_n) begin
            // saturate so long frames never alias a short length
            nxt_cnt = (cnt_base == sfp_pkg::CNT_MAX) ? cnt_base : cnt_base + 6'h01;
            nxt_ones = ones_base && lnk.io0 && lnk.io3;
            nxt_shift = {shift_ff[6:0], lnk.io0};
            if (xip_ff && cnt_base == sfp_pkg::XIP_DUMMY_POS && lnk.io0) begin
                nxt_xip = 1'b0;
            end
        end
        if (frame_end) begin
            if (ones_ff && rec_ff == REC_ARMED && cnt_ff == sfp_pkg::PLR_LEN) begin
                nxt_proto = sfp_pkg::PROTO_EXT;
                nxt_xip = 1'b0;
                nxt_lock = 1'b1;
                nxt_rec = REC_SEEK;
                nxt_idx = 3'h0;
            end else if (ones_ff && rec_ff == REC_ARMED && cnt_ff == sfp_pkg::RESCUE_LEN) begin
                // interface only: busy and array untouched
                nxt_proto = lock_ff ? sfp_pkg::PROTO_EXT : nonvolatile_config_reg_proto(nonvolatile_config_reg_ff);
                nxt_xip = lock_ff ? 1'b0 : !nonvolatile_config_reg_ff[sfp_pkg::NONVOLATILE_CONFIG_REG_XIP_BIT];
                nxt_rec = REC_SEEK;
                nxt_idx = 3'h0;
            end else if (ones_ff && rec_ff == REC_SEEK && cnt_ff == sfp_pkg::step1_len(idx_ff)) begin
                nxt_xip = 1'b0;
                if (idx_ff == sfp_pkg::STEP1_LAST) begin
                    nxt_rec = REC_ARMED;
                    nxt_idx = 3'h0;
                end else begin
                    nxt_idx = idx_ff + 3'h1;
                end
            end else begin
                // a broken sequence may still be the start of a new one
                nxt_rec = REC_SEEK;
                if (ones_ff && cnt_ff == sfp_pkg::STEP1_LEN0) begin
                    nxt_xip = 1'b0;
                    nxt_idx = 3'h1;
                end else begin
                    nxt_idx = 3'h0;
                end
                // only complete single-line bytes count as commands
                if (cnt_ff == sfp_pkg::CMD_LEN && proto_ff == sfp_pkg::PROTO_EXT && !xip_ff) begin
                    if (pmode_ff != sfp_pkg::PM_DPD || shift_ff == sfp_pkg::CMD_RELEASE_DPD) begin
                        nxt_cmdv = 1'b1;
                        nxt_cmd = shift_ff;
                    end
                end
            end
        end
        case (pmode_ff)
            sfp_pkg::PM_DPD: begin
                if (nxt_cmdv && nxt_cmd == sfp_pkg::CMD_RELEASE_DPD) begin
                    nxt_pmode = sfp_pkg::PM_STANDBY;
                end
            end
            default: begin
                if (nxt_cmdv && nxt_cmd == sfp_pkg::CMD_ENTER_DPD) begin
                    nxt_pmode = sfp_pkg::PM_DPD;
                end else if (!lnk.cs_n) begin
                    nxt_pmode = sfp_pkg::PM_ACTIVE;
                end else if (busy) begin
                    nxt_pmode = sfp_pkg::PM_ACTIVE;
                end else begin
                    nxt_pmode = sfp_pkg::PM_STANDBY;
                end
            end
        endcase
    end

    always_ff @(posedge lnk.sck or negedge nrst) begin
        if (!nrst) begin
            cs_prev_ff <= 1'b1;
            cnt_ff <= 6'h00;
            ones_ff <= 1'b0;
            shift_ff <= 8'h00;
            idx_ff <= 3'h0;
            rec_ff <= REC_SEEK;
            pmode_ff <= sfp_pkg::PM_STANDBY;
            proto_ff <= sfp_pkg::PROTO_EXT;
            xip_ff <= 1'b0;
            lock_ff <= 1'b0;
            init_ff <= 1'b0;
            nonvolatile_config_reg_ff <= sfp_pkg::NONVOLATILE_CONFIG_REG_RESET;
            status_ff <= sfp_pkg::STATUS_RESET;
            array_ff <= sfp_pkg::ARRAY_ERASED;
            cmdv_ff <= 1'b0;
            cmd_ff <= 8'h00;
        end else begin
            cs_prev_ff <= nxt_cs_prev;
            cnt_ff <= nxt_cnt;
            ones_ff <= nxt_ones;
            shift_ff <= nxt_shift;
            idx_ff <= nxt_idx;
            rec_ff <= nxt_rec;
            pmode_ff <= nxt_pmode;
            proto_ff <= nxt_proto;
            xip_ff <= nxt_xip;
            lock_ff <= nxt_lock;
            init_ff <= nxt_init;
            nonvolatile_config_reg_ff <= nxt_nonvolatile_config_reg;
            status_ff <= nxt_status;
            array_ff <= nxt_array;
            cmdv_ff <= nxt_cmdv;
            cmd_ff <= nxt_cmd;
        end
    end

    assign pmode = pmode_ff;
    assign proto = proto_ff;
    assign execute_in_place = xip_ff;
    assign status = status_ff;
    assign array_rd = array_ff;
    assign cmd_valid = cmdv_ff;
    assign cmd_code = cmd_ff;
endmodule

// File: rtl/sfp_host.sv
// host controller end: clock divider, commands and recovery sequences
`timescale 1ns/1ps
module sfp_host (
    sfp_if.host lnk,
    input wire logic clock,
    input wire logic nrst,
    input wire logic start,
    input wire sfp_pkg::sfp_op_type op,
    input wire logic [7:0] cmd,
    input wire logic ddr,
    output logic busy,
    output logic done
);
    typedef enum {H_IDLE, H_GAP, H_LOW} sfp_hst_type;

    sfp_hst_type st_ff, nxt_st;
    logic [1:0] div_ff, nxt_div;
    logic sck_ff, nxt_sck;
    logic cs_n_ff, nxt_cs_n;
    logic [7:0] sh_ff, nxt_sh;
    logic oe_ff, nxt_oe;
    sfp_pkg::sfp_op_type op_ff, nxt_op;
    logic [7:0] cmd_ff, nxt_cmdr;
    logic [2:0] step_ff, nxt_step;
    logic [5:0] bit_ff, nxt_bit;
    logic [2:0] gap_ff, nxt_gap;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic ddr_ff, nxt_ddr;
    logic tick, rise, fall;
    logic [5:0] len;
    logic [2:0] frames;

    always_comb begin
        tick = (div_ff == sfp_pkg::SCK_HALF_MAX);
        rise = tick && !sck_ff;
        fall = tick && sck_ff;
        nxt_div = tick ? 2'h0 : div_ff + 2'h1;
        nxt_sck = tick ? !sck_ff : sck_ff;
        case (op_ff)
            sfp_pkg::OP_PLR: len = (step_ff > sfp_pkg::STEP1_LAST) ? sfp_pkg::PLR_LEN : sfp_pkg::step1_len(step_ff);
            sfp_pkg::OP_RESCUE: len = (step_ff > sfp_pkg::STEP1_LAST) ? sfp_pkg::RESCUE_LEN : sfp_pkg::step1_len(step_ff);
            default: len = sfp_pkg::CMD_LEN;
        endcase
        frames = (op_ff == sfp_pkg::OP_CMD) ? 3'h1 : sfp_pkg::SEQ_FRAMES;
        nxt_st = st_ff;
        nxt_cs_n = cs_n_ff;
        nxt_sh = sh_ff;
        nxt_oe = 1'b1;
        nxt_op = op_ff;
        nxt_cmdr = cmd_ff;
        nxt_step = step_ff;
        nxt_bit = bit_ff;
        nxt_gap = (gap_ff == sfp_pkg::DESELECT_CYC_W) ? gap_ff : gap_ff + 3'h1;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_ddr = ddr_ff;
        case (st_ff)
            H_IDLE: begin
                if (start) begin
                    nxt_op = op;
                    nxt_cmdr = cmd;
                    nxt_ddr = ddr;
                    nxt_step = 3'h0;
                    nxt_busy = 1'b1;
                    nxt_gap = 3'h0;
                    nxt_st = H_GAP;
                end
            end
            H_GAP: begin
                // every frame of a sequence is spaced by the deselect minimum
                if (gap_ff == sfp_pkg::DESELECT_CYC_W) begin
                    if (step_ff == frames) begin
                        nxt_busy = 1'b0;
                        nxt_done = 1'b1;
                        nxt_st = H_IDLE;
                    end else if (fall) begin
                        nxt_cs_n = 1'b0;
                        nxt_bit = 6'h00;
                        // recovery frames keep data and hold lines at one
                        nxt_sh = (op_ff == sfp_pkg::OP_CMD) ? cmd_ff : sfp_pkg::ARRAY_ERASED;
                        nxt_st = H_LOW;
                    end
                end
            end
            H_LOW: begin
                if (rise) begin
                    nxt_bit = bit_ff + 6'h01;
                end
                if (fall) begin
                    // data changes on falling edges only, so in double rate both edges see ones
                    nxt_sh = {sh_ff[6:0], 1'b1};
                    if (bit_ff == len) begin
                        // raised before the next rising edge
                        nxt_cs_n = 1'b1;
                        nxt_step = step_ff + 3'h1;
                        nxt_gap = 3'h0;
                        nxt_st = H_GAP;
                    end
                end
            end
            default: nxt_st = H_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_ff <= H_IDLE;
            div_ff <= 2'h0;
            sck_ff <= 1'b0;
            cs_n_ff <= 1'b1;
            sh_ff <= 8'hff;
            oe_ff <= 1'b0;
            op_ff <= sfp_pkg::OP_CMD;
            cmd_ff <= 8'h00;
            step_ff <= 3'h0;
            bit_ff <= 6'h00;
            gap_ff <= 3'h0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            ddr_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            div_ff <= nxt_div;
            sck_ff <= nxt_sck;
            cs_n_ff <= nxt_cs_n;
            sh_ff <= nxt_sh;
            oe_ff <= nxt_oe;
            op_ff <= nxt_op;
            cmd_ff <= nxt_cmdr;
            step_ff <= nxt_step;
            bit_ff <= nxt_bit;
            gap_ff <= nxt_gap;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            ddr_ff <= nxt_ddr;
        end
    end

    assign lnk.sck = sck_ff;
    assign lnk.cs_n = cs_n_ff;
    assign lnk.io0_o = sh_ff[7];
    assign lnk.io0_oe = oe_ff;
    // hold line is never asserted by this controller
    assign lnk.io3_o = oe_ff;
    assign lnk.io3_oe = oe_ff;
    assign busy = busy_ff;
    assign done = done_ff;
endmodule

// File: verification/sfp_link_asserts.sv
// wire-level checks of the host side of the flash link
`timescale 1ns/1ps
module sfp_link_asserts (
    input wire logic clock,
    input wire logic nrst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic io0_oe,
    input wire logic io3_oe,
    input wire logic io0,
    input wire logic io3
);
    logic sck_d_ff;
    logic cs_d_ff;
    logic [5:0] rises_ff;
    logic nxt_sck_d;
    logic nxt_cs_d;
    logic [5:0] nxt_rises;
    // rises held through the first deselected cycle so the length can be judged there
    always_comb begin
        nxt_sck_d = sck;
        nxt_cs_d = cs_n;
        nxt_rises = rises_ff;
        if (cs_n && cs_d_ff) begin
            nxt_rises = 6'h00;
        end else if (!cs_n && sck && !sck_d_ff) begin
            nxt_rises = rises_ff + 6'h01;
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sck_d_ff <= 1'b0;
            cs_d_ff <= 1'b1;
            rises_ff <= 6'h00;
        end else begin
            sck_d_ff <= nxt_sck_d;
            cs_d_ff <= nxt_cs_d;
            rises_ff <= nxt_rises;
        end
    end
    default clocking dck @(posedge clock); endclocking
    default disable iff (!nrst);
    AST_CS_FALL_SCK_LOW: assert property ($fell(cs_n) |-> !sck)
        else $error("select fell with link clock high");
    AST_CS_RISE_SCK_LOW: assert property ($rose(cs_n) |-> !sck)
        else $error("select rose with link clock high");
    AST_DESELECT_MIN: assert property ($rose(cs_n) |-> cs_n [*2])
        else $error("deselect shorter than 50 ns");
    AST_LINES_DRIVEN: assert property (!cs_n |-> io0_oe && io3_oe)
        else $error("data lines not driven while selected");
    AST_HOLD_LINE_HIGH: assert property (!cs_n |-> io3)
        else $error("hold line low while selected");
    AST_SCK_DIV4: assert property ($rose(sck) |=> sck ##1 !sck [*2] ##1 sck)
        else $error("link clock not an even divide by four");
    AST_IO0_ON_FALL: assert property ((!cs_n && !$past(cs_n) && $changed(io0)) |-> $fell(sck))
        else $error("data changed away from the falling clock");
    AST_FRAME_LEN_MAX: assert property (!cs_n |-> rises_ff <= 6'h21)
        else $error("frame longer than 33 clocks");
    AST_FRAME_LEN_LEGAL: assert property ($rose(cs_n) |->
        rises_ff inside {6'h07, 6'h08, 6'h09, 6'h0d, 6'h10, 6'h11, 6'h19, 6'h21})
        else $error("frame length not a legal count");
    AST_FRAME_BOUNDED: assert property (!cs_n |-> ##[1:140] cs_n)
        else $error("select held low too long");
endmodule

// File: verification/tb_top.sv
// bench: host and device joined on one link, a rule-breaking driver on a second
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic [5:0] len; logic [7:0] dat;} sfp_exp_type;
    logic clock = 1'b0, nrst = 1'b1, dev_nrst = 1'b1, dev2_nrst = 1'b1, start = 1'b0, ddr = 1'b0;
    logic busy = 1'b0, nonvolatile_config_reg_wr = 1'b0, pwr_loss = 1'b0, wones = 1'b1;
    logic [7:0] cmd = 8'h00;
    logic [15:0] nonvolatile_config_reg_wdata = 16'hffff;
    sfp_pkg::sfp_op_type op = sfp_pkg::OP_CMD;
    sfp_pkg::sfp_pmode_type pmode;
    sfp_pkg::sfp_proto_type proto, proto2;
    logic execute_in_place, xip2, hbusy, hdone, cmd_valid;
    logic [7:0] status, array_rd, cmd_code, wsh, c;
    logic [31:0] rng = 32'h861f_500d;
    int wlen = 0, n_fail = 0, comparisons = 0, cycles = 0;
    int lens[6] = '{7, 9, 13, 17, 25, 33};
    logic [15:0] tbl_nonvolatile_config_reg[3] = '{16'hff77, 16'hffbf, 16'hffff};
    sfp_pkg::sfp_proto_type tbl_proto[3] = '{sfp_pkg::PROTO_QUAD, sfp_pkg::PROTO_DUAL, sfp_pkg::PROTO_EXT};
    logic tbl_xip[3] = '{1'b1, 1'b0, 1'b0};
    sfp_exp_type e;
    sfp_exp_type q_frm[$];
    logic [7:0] q_cmd[$];
    sfp_if lnk();
    sfp_if lnk2();
    sfp_host sfp_host_i (.lnk(lnk), .clock(clock), .nrst(nrst), .start(start), .op(op), .cmd(cmd), .ddr(ddr),
        .busy(hbusy), .done(hdone));
    sfp_dev sfp_dev_i (.lnk(lnk), .nrst(dev_nrst), .busy(busy), .nonvolatile_config_reg_wr(nonvolatile_config_reg_wr), .nonvolatile_config_reg_wdata(nonvolatile_config_reg_wdata),
        .pwr_loss(pwr_loss), .pmode(pmode), .proto(proto), .execute_in_place(execute_in_place), .status(status), .array_rd(array_rd),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code));
    // second device sees only the bench driver, which breaks the host rules on purpose
    sfp_dev sfp_dev_i2 (.lnk(lnk2), .nrst(dev2_nrst), .busy(1'b0), .nonvolatile_config_reg_wr(1'b0), .nonvolatile_config_reg_wdata(16'hffff),
        .pwr_loss(1'b1), .pmode(), .proto(proto2), .execute_in_place(xip2), .status(), .array_rd(), .cmd_valid(), .cmd_code());
    sfp_link_asserts sfp_link_asserts_i (.clock(clock), .nrst(nrst), .sck(lnk.sck), .cs_n(lnk.cs_n),
        .io0_oe(lnk.io0_oe), .io3_oe(lnk.io3_oe), .io0(lnk.io0), .io3(lnk.io3));
    always #12.5 clock = ~clock;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction
    task automatic chk(input logic ok, input string what);
        comparisons++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic sck_wait(input int n);
        repeat (n) @(posedge lnk.sck);
        #1;
    endtask
    task automatic nonvolatile_config_reg_set(input logic [15:0] v);
        sck_wait(1);
        nonvolatile_config_reg_wdata = v;
        nonvolatile_config_reg_wr = 1'b1;
        sck_wait(1);
        nonvolatile_config_reg_wr = 1'b0;
    endtask
    // one host request; wire frames and accepted command codes are noted first
    task automatic run(input sfp_pkg::sfp_op_type o, input logic [7:0] cb, input logic acc);
        int n;
        if (o == sfp_pkg::OP_CMD) q_frm.push_back({6'h08, cb});
        else begin
            foreach (lens[i]) q_frm.push_back({6'(lens[i]), 8'hff});
            q_frm.push_back({(o == sfp_pkg::OP_PLR) ? 6'h08 : 6'h10, 8'hff});
        end
        if (acc) q_cmd.push_back(cb);
        @(posedge clock);
        #1;
        start = 1'b1;
        op = o;
        cmd = cb;
        ddr = rng[0];
        rng = xs(rng);
        @(posedge clock);
        #1;
        start = 1'b0;
        chk(hbusy === 1'b1, "host busy after start");
        n = 0;
        while (hdone !== 1'b1 && n < 4000) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk(hdone === 1'b1, "host never finished");
        chk(hbusy === 1'b0, "host still busy with done");
        repeat (16) @(posedge clock);
        #1;
    endtask
    // bench-made link clock, 160 ns, only around frames
    task automatic pulses(input int n);
        repeat (n) begin
            #80 lnk2.sck = 1'b1;
            #80 lnk2.sck = 1'b0;
        end
    endtask
    task automatic frame2(input int len, input int bad);
        lnk2.cs_n = 1'b0;
        lnk2.io0_oe = 1'b1;
        for (int i = 0; i < len; i++) begin
            lnk2.io0_o = (i == bad) ? 1'b0 : 1'b1;
            pulses(1);
        end
        lnk2.cs_n = 1'b1;
        lnk2.io0_oe = 1'b0;
        pulses(3);
    endtask
    always @(posedge lnk.sck) begin
        if (lnk.cs_n === 1'b0) begin
            wlen++;
            wsh = {wsh[6:0], lnk.io0};
            wones = wones & lnk.io0 & lnk.io3;
        end
    end
    always @(posedge lnk.cs_n) begin
        if (nrst === 1'b1) begin
            if (q_frm.size() == 0) chk(1'b0, "unexpected frame");
            else begin
                e = q_frm.pop_front();
                chk(wlen == e.len && wsh === e.dat && (e.dat != 8'hff || wones), "frame on wire");
            end
            // short frames leave the top bits as preset, not as the last frame's tail
            wsh = 8'hff;
            wlen = 0;
            wones = 1'b1;
        end
    end
    always @(negedge lnk.sck) begin
        if (cmd_valid === 1'b1) begin
            chk(q_cmd.size() > 0 && cmd_code === q_cmd[0], "command taken by device");
            if (q_cmd.size() > 0) void'(q_cmd.pop_front());
        end
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("CHECK FAILED at %0t: run took too long", $time);
            report_and_stop();
        end
    end
    initial begin
        lnk2.sck = 1'b0;
        lnk2.cs_n = 1'b1;
        lnk2.io0_o = 1'b1;
        lnk2.io0_oe = 1'b0;
        lnk2.io3_o = 1'b1;
        lnk2.io3_oe = 1'b1;
        // reset must arrive as a falling edge: the device clock is at rest until the host runs
        #1;
        nrst = 1'b0;
        dev_nrst = 1'b0;
        dev2_nrst = 1'b0;
        repeat (6) @(posedge clock);
        #1;
        nrst = 1'b1;
        dev_nrst = 1'b1;
        sck_wait(4);
        chk(status === 8'h00, "status as delivered");
        chk(array_rd === 8'hff, "array as delivered");
        chk(proto === sfp_pkg::PROTO_EXT && execute_in_place === 1'b0, "config as delivered");
        chk(pmode === sfp_pkg::PM_STANDBY, "idle device in standby");
        $display("test delivery done");
        repeat (4) begin
            c = rng[7:0] ^ ((rng[7:0] == 8'h5a || rng[7:0] == 8'ha5) ? 8'h01 : 8'h00);
            rng = xs(rng);
            fork
                run(sfp_pkg::OP_CMD, c, 1'b1);
                begin
                    repeat (20) @(posedge clock);
                    #1;
                    chk(pmode === sfp_pkg::PM_ACTIVE, "active while selected");
                end
            join
        end
        busy = 1'b1;
        sck_wait(3);
        chk(pmode === sfp_pkg::PM_ACTIVE && status[0] === 1'b1, "active while busy");
        busy = 1'b0;
        sck_wait(3);
        chk(pmode === sfp_pkg::PM_STANDBY, "standby once work ends");
        run(sfp_pkg::OP_CMD, 8'h5a, 1'b1);
        chk(pmode === sfp_pkg::PM_DPD, "deep power-down entered");
        run(sfp_pkg::OP_CMD, 8'h3c, 1'b0);
        chk(pmode === sfp_pkg::PM_DPD, "other command ignored when down");
        run(sfp_pkg::OP_CMD, 8'ha5, 1'b1);
        chk(pmode === sfp_pkg::PM_STANDBY, "deep power-down left");
        $display("test power modes done");
        // rescue with work in progress: interface follows config, work untouched
        for (int k = 0; k < 3; k++) begin
            nonvolatile_config_reg_set(tbl_nonvolatile_config_reg[k]);
            busy = 1'b1;
            run(sfp_pkg::OP_RESCUE, 8'h00, 1'b0);
            chk(proto === tbl_proto[k] && execute_in_place === tbl_xip[k], "interface after rescue");
            chk(status[0] === 1'b1 && pmode === sfp_pkg::PM_ACTIVE, "work kept running");
            busy = 1'b0;
            run(sfp_pkg::OP_CMD, 8'h3c, k == 2);
        end
        $display("test rescue done");
        dev_nrst = 1'b0;
        pwr_loss = 1'b1;
        sck_wait(2);
        dev_nrst = 1'b1;
        sck_wait(3);
        pwr_loss = 1'b0;
        chk(proto === sfp_pkg::PROTO_QUAD && execute_in_place === 1'b1, "torn write start state");
        run(sfp_pkg::OP_PLR, 8'h00, 1'b0);
        chk(proto === sfp_pkg::PROTO_EXT && execute_in_place === 1'b0, "power-loss recovery");
        nonvolatile_config_reg_set(16'hff77);
        run(sfp_pkg::OP_RESCUE, 8'h00, 1'b0);
        chk(proto === sfp_pkg::PROTO_EXT && execute_in_place === 1'b0, "kept until power-up");
        run(sfp_pkg::OP_CMD, 8'h3c, 1'b1);
        $display("test power loss done");
        pulses(2);
        dev2_nrst = 1'b1;
        pulses(2);
        frame2(26, 24);
        chk(xip2 === 1'b1, "confirm bit zero keeps xip");
        frame2(26, 99);
        chk(xip2 === 1'b0, "confirm bit one ends xip");
        for (int k = 0; k < 6; k++) frame2(lens[k], (k == 3) ? 5 : 99);
        frame2(8, 99);
        chk(proto2 === sfp_pkg::PROTO_QUAD, "broken first step refused");
        frame2(8, 99);
        for (int k = 0; k < 6; k++) frame2(lens[k], 99);
        chk(proto2 === sfp_pkg::PROTO_QUAD, "second step first refused");
        frame2(8, 99);
        chk(proto2 === sfp_pkg::PROTO_EXT, "ordered recovery accepted");
        $display("test faulty host done");
        chk(q_frm.size() == 0 && q_cmd.size() == 0, "expected traffic missing");
        report_and_stop();
    end
endmodule
